// File: hw/index_vertex_params.svh
// Constants for the index and vertex source state fetch block.
// Included by the design; definitions only.
`ifndef INDEX_VERTEX_PARAMS_SVH
`define INDEX_VERTEX_PARAMS_SVH
// Command header decode
`define HDR_TYPE_HI 31
`define HDR_TYPE_LO 29
`define HDR_CLASS_VALUE 3'h3
`define HDR_SUBTYPE_VALUE 2'h3
`define HDR_OPCODE_VALUE 3'h0
`define SUBOP_INDEX_STATE 8'h0A
`define SUBOP_VERTEX_STATE 8'h08
`define HDR_RSVD_HI 15
`define HDR_RSVD_LO 8
`define HDR_LEN_HI 7
`define HDR_LEN_LO 0
`define IB_LEN_DEFAULT 8'h01
`define IB_MOC_HI 15
`define IB_MOC_LO 12
`define IB_CUT_BIT 10
`define IB_WIDTH_HI 9
`define IB_WIDTH_LO 8
// Per-buffer structure, first dword fields, slot count and length limit
`define VB_SLOT_HI 31
`define VB_SLOT_LO 26
`define VB_ACCESS_BIT 20
`define VB_MOC_HI 19
`define VB_MOC_LO 16
`define VB_SLOT_COUNT 33
`define VB_LEN_MAX 8'h83
// Register map and reset values
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_CUTS 4'h8
`define CTRL_RESET 32'h0000_0001
`endif

// File: hw/index_vertex_pkg.sv
// Types shared by the index and vertex source state fetch block.
// Uses nothing from the constants header.
package index_vertex_pkg;
    typedef enum logic [1:0] {WIDTH_BYTE, WIDTH_WORD, WIDTH_FULL, WIDTH_BAD} index_width_type;
    typedef enum logic [4:0] {
        TOPO_POINTLIST, TOPO_LINELIST, TOPO_LINESTRIP, TOPO_TRILIST, TOPO_TRISTRIP, TOPO_TRIFAN,
        TOPO_QUADLIST, TOPO_QUADSTRIP, TOPO_LINELIST_ADJ, TOPO_LINESTRIP_ADJ, TOPO_TRILIST_ADJ,
        TOPO_TRISTRIP_ADJ, TOPO_TRISTRIP_REVERSE, TOPO_POLYGON, TOPO_RECTLIST, TOPO_LINELOOP,
        TOPO_POINTLIST_BF, TOPO_LINESTRIP_CONT, TOPO_LINESTRIP_BF, TOPO_LINESTRIP_CONT_BF,
        TOPO_TRIFAN_NOSTIPPLE, TOPO_PATCHLIST
    } topology_type;
    typedef enum logic {PER_VERTEX_ACCESS, PER_INSTANCE_ACCESS} fetch_mode_select_type;
    typedef struct packed {
        logic cut_enable;
        index_width_type width;
        logic [3:0] moc;
        logic [31:0] start;
        logic [31:0] last;
    } ib_state_type;
    typedef struct packed {
        logic defined;
        fetch_mode_select_type mode;
        logic [3:0] moc;
        logic [31:0] base;
        logic [31:0] last;
    } vb_state_type;
endpackage : index_vertex_pkg

// File: hw/index_vertex_buffer_state_fetch.sv
// Index and vertex source state decode plus index and vertex fetch.
// Assumes one clock, a pulse-per-request fetch master, and a memory
// that answers each one-cycle read request with one i_mem_valid pulse.
//
// Operation
// R1 - With cut enabled, all-ones index of current width is a cut marker.
// R2 - With cut disabled, all-ones index is an ordinary vertex index.
// R3 - Index width field: byte, word, fullword; index values always unsigned.
// R4 - Index command length field is total length minus two, default one.
// R5 - Second dword is the size-aligned start address of the first index.
// R6 - Non-zero end address: index reads past that byte return zero.
// R7 - Software puts the end address on an index boundary.
// R8 - Software keeps index buffers in linear memory only.
// R9 - Software avoids cut enable with topologies lacking cut support.
// R10 - Cut markers supported only by the listed list and strip topologies.
// R11 - Each buffer addressed by vertex or instance index per its mode.
// R12 - Accesses outside a buffer's extent return zero data.
// R13 - One vertex command carries one to 33 structures, each naming a slot.
// R14 - Slots absent from a vertex command keep their stored state.
// R15 - Software sends at least one complete structure per command.
// R16 - Structures are four dwords; length field equals 4n-1.
// R17 - Software defines each slot at most once per command.
// R18 - Vertex command: type 3, sub-opcode 08h, bits 15:8 zero.
// R19 - Generated-only elements ignore buffer state and need no buffer.
// R20 - Structure bits 31:26 give the slot number, range 0 to 32.
// R21 - Bit 20 selects per-vertex or per-instance fetch mode.
// R22 - Bits 19:16 give memory object control for that buffer's fetches.
// R23 - Index command: type 3, subtype 3, opcode 0, sub-opcode 0Ah.
// R24 - Random draws fetch indices; sequential draws use positions directly.
// R25 - A cut marker ends the primitive and fetches no vertex data.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "index_vertex_params.svh"

module index_vertex_buffer_state_fetch
    import index_vertex_pkg::*;
#(
    parameter int SLOTS = `VB_SLOT_COUNT
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Command stream
    input wire logic i_cmd_valid,
    input wire logic [31:0] i_cmd_dword,
    output logic o_cmd_ready,
    // Fetch requests
    output logic o_fetch_ready,
    input wire logic i_idx_req,
    input wire logic i_idx_random,
    input wire logic [31:0] i_idx_position,
    input wire topology_type i_idx_topology,
    output logic o_idx_done,
    output logic o_idx_cut,
    output logic [31:0] o_idx_value,
    input wire logic i_vtx_req,
    input wire logic [5:0] i_vtx_slot,
    input wire logic i_vtx_generated_only,
    input wire logic [31:0] i_vtx_vertex_index,
    input wire logic [31:0] i_vtx_instance_index,
    input wire logic [15:0] i_vtx_stride,
    input wire logic [15:0] i_vtx_offset,
    output logic o_vtx_done,
    output logic [31:0] o_vtx_data,
    // Graphics memory
    output logic o_mem_req,
    output logic [31:0] o_mem_addr,
    output logic [3:0] o_mem_moc,
    input wire logic i_mem_valid,
    input wire logic [31:0] i_mem_data,
    // Register port
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    output logic [31:0] o_reg_rdata
);
    typedef enum logic [1:0] {CP_HEADER, CP_IB_BODY, CP_VB_BODY} cp_state_type;
    typedef enum logic [1:0] {F_IDLE, F_IDX_WAIT, F_VTX_WAIT} f_state_type;

    cp_state_type cp_state_reg, cp_next;
    f_state_type f_state_reg, f_next;
    logic [7:0] cp_count_reg;
    logic [1:0] cp_pos_reg;
    ib_state_type ib_reg;
    vb_state_type vb_reg [SLOTS];
    vb_state_type vb_pend_reg;
    logic [5:0] vb_slot_reg;
    logic [31:0] ctrl_reg, cuts_reg, idx_addr_reg;
    logic topo_err_reg, cmd_err_reg, len_err_reg;

    logic cmd_take, fetch_take, idx_take, vtx_take;
    logic is_ib_hdr, is_vb_hdr, vb_len_bad, idx_beyond, vtx_beyond, vtx_slot_ok;
    logic [7:0] hdr_len;
    logic [31:0] idx_addr, vtx_index, vtx_addr, fetched_index, all_ones;
    vb_state_type vtx_state;

    assign cmd_take = i_cmd_valid && o_cmd_ready;
    assign fetch_take = o_fetch_ready && !cmd_take;
    assign idx_take = fetch_take && i_idx_req;
    assign vtx_take = fetch_take && i_vtx_req && !i_idx_req;
    assign hdr_len = i_cmd_dword[`HDR_LEN_HI:`HDR_LEN_LO];

    // R23 index command decode
    assign is_ib_hdr = i_cmd_dword[31:16] ==
        {`HDR_CLASS_VALUE, `HDR_SUBTYPE_VALUE, `HDR_OPCODE_VALUE, `SUBOP_INDEX_STATE};
    // R18 vertex command decode
    assign is_vb_hdr = i_cmd_dword[31:16] ==
        {`HDR_CLASS_VALUE, `HDR_SUBTYPE_VALUE, `HDR_OPCODE_VALUE, `SUBOP_VERTEX_STATE}
        && i_cmd_dword[`HDR_RSVD_HI:`HDR_RSVD_LO] == 8'h00;
    // R13 R16 length must be 4n-1 with n from 1 to 33
    assign vb_len_bad = hdr_len[1:0] != 2'h3 || hdr_len > `VB_LEN_MAX;

    // R5 first index at start, scaled by index size
    assign idx_addr = ib_reg.start + (i_idx_position << ib_reg.width);
    // R6 end address zero means unchecked
    assign idx_beyond = ib_reg.last != 32'h0000_0000 && idx_addr > ib_reg.last;

    assign vtx_slot_ok = i_vtx_slot < 6'(SLOTS);
    assign vtx_state = vb_reg[vtx_slot_ok ? i_vtx_slot : 6'h00];
    // R11 mode picks which computed index walks the buffer
    assign vtx_index = vtx_state.mode == PER_INSTANCE_ACCESS ? i_vtx_instance_index : i_vtx_vertex_index;
    assign vtx_addr = vtx_state.base + vtx_index * 32'(i_vtx_stride) + 32'(i_vtx_offset);
    // R12 straddling the last byte counts as outside
    assign vtx_beyond = !vtx_slot_ok || !vtx_state.defined || vtx_addr < vtx_state.base
        || vtx_addr + 32'h0000_0003 > vtx_state.last;

    // R3 unsigned zero-extended extract from the aligned dword
    always_comb begin
        fetched_index = 32'h0000_0000;
        all_ones = 32'h0000_0000;
        unique case (ib_reg.width)
            WIDTH_BYTE: begin
                fetched_index = 32'(i_mem_data[{idx_addr_reg[1:0], 3'h0} +: 8]);
                all_ones = 32'h0000_00FF;
            end
            WIDTH_WORD: begin
                fetched_index = 32'(i_mem_data[{idx_addr_reg[1], 4'h0} +: 16]);
                all_ones = 32'h0000_FFFF;
            end
            default: begin
                fetched_index = i_mem_data;
                all_ones = 32'hFFFF_FFFF;
            end
        endcase
    end

    // R10 topologies that accept cut markers
    function automatic logic cut_supported(input topology_type topo);
        unique case (topo)
            TOPO_TRIFAN, TOPO_QUADLIST, TOPO_QUADSTRIP, TOPO_POLYGON, TOPO_RECTLIST,
            TOPO_LINELOOP, TOPO_TRIFAN_NOSTIPPLE, TOPO_PATCHLIST: cut_supported = 1'b0;
            default: cut_supported = 1'b1;
        endcase
    endfunction : cut_supported

    always_comb begin
        cp_next = cp_state_reg;
        if (cmd_take) begin
            unique case (cp_state_reg)
                CP_HEADER: begin
                    if (is_ib_hdr) begin
                        cp_next = CP_IB_BODY;
                    end else if (is_vb_hdr) begin
                        cp_next = CP_VB_BODY;
                    end
                end
                CP_IB_BODY, CP_VB_BODY: begin
                    if (cp_count_reg == 8'h00) begin
                        cp_next = CP_HEADER;
                    end
                end
            endcase
        end
    end

    always_comb begin
        f_next = f_state_reg;
        unique case (f_state_reg)
            F_IDLE: begin
                if (idx_take && i_idx_random && !idx_beyond) begin
                    f_next = F_IDX_WAIT;
                end else if (vtx_take && !i_vtx_generated_only && !vtx_beyond) begin
                    f_next = F_VTX_WAIT;
                end
            end
            F_IDX_WAIT, F_VTX_WAIT: begin
                if (i_mem_valid) begin
                    f_next = F_IDLE;
                end
            end
        endcase
    end

    // Parser and fetcher never overlap, so state cannot change under a fetch
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cp_state_reg <= CP_HEADER;
            f_state_reg <= F_IDLE;
            o_cmd_ready <= 1'b0;
            o_fetch_ready <= 1'b0;
        end else begin
            cp_state_reg <= cp_next;
            f_state_reg <= f_next;
            o_cmd_ready <= f_next == F_IDLE;
            o_fetch_ready <= cp_next == CP_HEADER && f_next == F_IDLE && !(idx_take || vtx_take) && ctrl_reg[0];
        end
    end

    // R4 R16 body dword count comes straight from the length field
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cp_count_reg <= 8'h00;
            cp_pos_reg <= 2'h0;
        end else if (cmd_take) begin
            if (cp_state_reg == CP_HEADER) begin
                cp_count_reg <= hdr_len;
                cp_pos_reg <= 2'h0;
            end else begin
                cp_count_reg <= cp_count_reg - 8'h01;
                cp_pos_reg <= cp_pos_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ib_reg <= '0;
        end else if (cmd_take && cp_state_reg == CP_HEADER && is_ib_hdr) begin
            // R1 R2 R3 cut enable and width latched with the header
            ib_reg.cut_enable <= i_cmd_dword[`IB_CUT_BIT];
            ib_reg.width <= index_width_type'(i_cmd_dword[`IB_WIDTH_HI:`IB_WIDTH_LO]);
            ib_reg.moc <= i_cmd_dword[`IB_MOC_HI:`IB_MOC_LO];
        end else if (cmd_take && cp_state_reg == CP_IB_BODY && cp_pos_reg == 2'h0) begin
            ib_reg.start <= i_cmd_dword;
        end else if (cmd_take && cp_state_reg == CP_IB_BODY && cp_pos_reg == 2'h1) begin
            ib_reg.last <= i_cmd_dword;
        end
    end

    // R20 R21 R22 first dword of a structure names slot, mode and control
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            vb_pend_reg <= '0;
            vb_slot_reg <= 6'h00;
        end else if (cmd_take && cp_state_reg == CP_VB_BODY && cp_pos_reg == 2'h0) begin
            vb_slot_reg <= i_cmd_dword[`VB_SLOT_HI:`VB_SLOT_LO];
            vb_pend_reg.mode <= fetch_mode_select_type'(i_cmd_dword[`VB_ACCESS_BIT]);
            vb_pend_reg.moc <= i_cmd_dword[`VB_MOC_HI:`VB_MOC_LO];
        end else if (cmd_take && cp_state_reg == CP_VB_BODY && cp_pos_reg == 2'h1) begin
            vb_pend_reg.base <= i_cmd_dword;
        end
    end

    // R14 only the named slot is written, on the structure's third dword; a structure cut short before that writes nothing
    generate
        for (genvar s = 0; s < SLOTS; s++) begin : g_slot
            always_ff @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    vb_reg[s] <= '0;
                end else if (cmd_take && cp_state_reg == CP_VB_BODY && cp_pos_reg == 2'h2
                             && vb_slot_reg == 6'(s)) begin
                    vb_reg[s] <= '{1'b1, vb_pend_reg.mode, vb_pend_reg.moc, vb_pend_reg.base, i_cmd_dword};
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_mem_req <= 1'b0;
            o_mem_addr <= 32'h0000_0000;
            o_mem_moc <= 4'h0;
            idx_addr_reg <= 32'h0000_0000;
        end else begin
            o_mem_req <= f_state_reg == F_IDLE && f_next != F_IDLE;
            if (idx_take) begin
                idx_addr_reg <= idx_addr;
                o_mem_addr <= {idx_addr[31:2], 2'h0};
                o_mem_moc <= ib_reg.moc;
            end else if (vtx_take) begin
                o_mem_addr <= vtx_addr;
                // R22 buffer control travels with every fetch
                o_mem_moc <= vtx_state.moc;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_idx_done <= 1'b0;
            o_idx_cut <= 1'b0;
            o_idx_value <= 32'h0000_0000;
        end else begin
            o_idx_done <= 1'b0;
            o_idx_cut <= 1'b0;
            if (idx_take && !i_idx_random) begin
                // R24 sequential draw needs no index buffer
                o_idx_done <= 1'b1;
                o_idx_value <= i_idx_position;
            end else if (idx_take && idx_beyond) begin
                // R6 read past the end behaves as zero-extended
                o_idx_done <= 1'b1;
                o_idx_value <= 32'h0000_0000;
            end else if (f_state_reg == F_IDX_WAIT && i_mem_valid) begin
                o_idx_done <= 1'b1;
                // R1 R25 marker flagged, no vertex index handed on
                if (ib_reg.cut_enable && fetched_index == all_ones) begin
                    o_idx_cut <= 1'b1;
                    o_idx_value <= 32'h0000_0000;
                end else begin
                    // R2 all-ones passes as a plain index
                    o_idx_value <= fetched_index;
                end
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_vtx_done <= 1'b0;
            o_vtx_data <= 32'h0000_0000;
        end else begin
            o_vtx_done <= 1'b0;
            if (vtx_take && (i_vtx_generated_only || vtx_beyond)) begin
                // R12 R19 zero answer with no memory touch
                o_vtx_done <= 1'b1;
                o_vtx_data <= 32'h0000_0000;
            end else if (f_state_reg == F_VTX_WAIT && i_mem_valid) begin
                o_vtx_done <= 1'b1;
                o_vtx_data <= i_mem_data;
            end
        end
    end

    // Status flags: a new event wins over a write-one clear in the same cycle
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg <= `CTRL_RESET;
            topo_err_reg <= 1'b0;
            cmd_err_reg <= 1'b0;
            len_err_reg <= 1'b0;
            cuts_reg <= 32'h0000_0000;
        end else begin
            if (i_reg_write && i_reg_addr == `REG_CTRL) begin
                ctrl_reg <= {31'h0000_0000, i_reg_wdata[0]};
            end
            // R9 the violation is recorded, not blocked
            topo_err_reg <= (idx_take && i_idx_random && ib_reg.cut_enable && !cut_supported(i_idx_topology))
                || (topo_err_reg && !(i_reg_write && i_reg_addr == `REG_STATUS && i_reg_wdata[3]));
            cmd_err_reg <= (cmd_take && cp_state_reg == CP_HEADER && !is_ib_hdr && !is_vb_hdr)
                || (cmd_take && cp_state_reg == CP_VB_BODY && cp_pos_reg == 2'h0
                    && i_cmd_dword[`VB_SLOT_HI:`VB_SLOT_LO] >= 6'(SLOTS))
                || (cmd_err_reg && !(i_reg_write && i_reg_addr == `REG_STATUS && i_reg_wdata[4]));
            len_err_reg <= (cmd_take && cp_state_reg == CP_HEADER && is_vb_hdr && vb_len_bad)
                || (len_err_reg && !(i_reg_write && i_reg_addr == `REG_STATUS && i_reg_wdata[5]));
            if (f_state_reg == F_IDX_WAIT && i_mem_valid && ib_reg.cut_enable && fetched_index == all_ones) begin
                cuts_reg <= cuts_reg + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 32'h0000_0000;
        end else if (i_reg_read) begin
            unique case (i_reg_addr)
                `REG_CTRL: o_reg_rdata <= ctrl_reg;
                `REG_STATUS: o_reg_rdata <= {26'h0, len_err_reg, cmd_err_reg, topo_err_reg,
                                             ib_reg.width, ib_reg.cut_enable};
                `REG_CUTS: o_reg_rdata <= cuts_reg;
                default: o_reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_reg_rdata <= 32'h0000_0000;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence s_cut_read;
        f_state_reg == F_IDX_WAIT && i_mem_valid && ib_reg.cut_enable && fetched_index == all_ones;
    endsequence
    sequence s_marker_out;
        o_idx_done && o_idx_cut && o_idx_value == 32'h0000_0000 && !o_mem_req;
    endsequence

    a_cut_marker: assert property (s_cut_read |=> s_marker_out) // R1
        else $error("cut marker not flagged");
    a_cut_disabled: assert property (o_idx_cut |-> ib_reg.cut_enable) // R2
        else $error("cut flagged while disabled");
    a_width_latch: assert property (cmd_take && cp_state_reg == CP_HEADER && is_ib_hdr
        |=> ib_reg.width == index_width_type'($past(i_cmd_dword[9:8]))) // R3
        else $error("index width not latched");
    a_ib_past_end: assert property (idx_take && i_idx_random && idx_beyond
        |=> o_idx_done && o_idx_value == 32'h0000_0000 && !o_mem_req) // R6
        else $error("index past end not zero");
    a_vb_outside: assert property (vtx_take && !i_vtx_generated_only && vtx_beyond
        |=> o_vtx_done && o_vtx_data == 32'h0000_0000 && f_state_reg == F_IDLE) // R12
        else $error("outside access not zero");
    a_vb_length: assert property (cmd_take && cp_state_reg == CP_HEADER && is_vb_hdr && vb_len_bad
        |=> len_err_reg) // R16
        else $error("bad vertex length not flagged");
    a_vb_header: assert property (cmd_take && cp_state_reg == CP_HEADER && is_vb_hdr
        |=> cp_state_reg == CP_VB_BODY && !o_fetch_ready) // R18
        else $error("vertex header not decoded");
    a_generated_only: assert property (vtx_take && i_vtx_generated_only
        |=> o_vtx_done && !o_mem_req ##1 !o_vtx_done) // R19
        else $error("generated-only element fetched");
    a_moc_select: assert property (f_state_reg == F_IDLE && f_next == F_VTX_WAIT
        |=> o_mem_req && o_mem_moc == $past(vtx_state.moc)) // R22
        else $error("wrong memory control on fetch");
    a_seq_mode: assert property (idx_take && !i_idx_random
        |=> o_idx_done && o_idx_value == $past(i_idx_position) && !o_mem_req) // R24
        else $error("sequential index wrong");
endmodule : index_vertex_buffer_state_fetch
`default_nettype wire

// File: testbench/fetch_memory_model.sv
// Graphics memory model facing the block's read port.
// Assumes one-cycle read requests with at most one outstanding.
`timescale 1ns/1ps
`default_nettype none
module fetch_memory_model (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Read port
    input wire logic i_req,
    input wire logic [31:0] i_addr,
    input wire logic i_slow,
    output logic o_valid,
    output logic [31:0] o_data
);
    logic [7:0] wait_reg;
    logic [31:0] addr_reg;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            wait_reg <= 8'h00;
            addr_reg <= 32'h0000_0000;
            o_valid <= 1'b0;
            o_data <= 32'h0000_0000;
        end else begin
            o_valid <= 1'b0;
            // Data toggles outside answers so stale values never match
            o_data <= ~o_data;
            if (i_req) begin
                wait_reg <= i_slow ? 8'h06 : 8'h01;
                addr_reg <= i_addr;
            end else if (wait_reg != 8'h00) begin
                wait_reg <= wait_reg - 8'h01;
                if (wait_reg == 8'h01) begin
                    o_valid <= 1'b1;
                    o_data <= {16'hFFFF, addr_reg[15:0]};
                end
            end
        end
    end
endmodule : fetch_memory_model
`default_nettype wire

// File: testbench/index_vertex_buffer_state_fetch_tb.sv
// Self-checking bench for the index and vertex source state fetch block.
// Assumes the package, the design and the memory model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module index_vertex_buffer_state_fetch_tb;
    import index_vertex_pkg::*;
    logic i_clock = 0, i_rst = 1, i_cmd_valid = 0, i_idx_req = 0, i_idx_random = 1, i_vtx_req = 0;
    logic i_vtx_generated_only = 0, i_reg_write = 0, i_reg_read = 0, slow = 0, got_cut;
    logic [31:0] i_cmd_dword = '0, i_idx_position = '0, i_vtx_vertex_index = '0, i_vtx_instance_index = '0;
    logic [31:0] i_reg_wdata = '0, got, o_idx_value, o_vtx_data, o_mem_addr, i_mem_data, o_reg_rdata;
    logic [15:0] i_vtx_stride = 16'h0010, i_vtx_offset = 16'h0004;
    logic [5:0] i_vtx_slot = '0;
    logic [3:0] i_reg_addr = '0, o_mem_moc, got_moc;
    topology_type i_idx_topology = TOPO_TRILIST;
    logic o_cmd_ready, o_fetch_ready, o_idx_done, o_idx_cut, o_vtx_done, o_mem_req, i_mem_valid;
    int fails = 0, compares = 0, cycles = 0;
    always #20 i_clock = ~i_clock;
    index_vertex_buffer_state_fetch i_dut (.i_clock, .i_rst, .i_cmd_valid, .i_cmd_dword, .o_cmd_ready,
        .o_fetch_ready, .i_idx_req, .i_idx_random, .i_idx_position, .i_idx_topology, .o_idx_done, .o_idx_cut,
        .o_idx_value, .i_vtx_req, .i_vtx_slot, .i_vtx_generated_only, .i_vtx_vertex_index, .i_vtx_instance_index,
        .i_vtx_stride, .i_vtx_offset, .o_vtx_done, .o_vtx_data, .o_mem_req, .o_mem_addr, .o_mem_moc,
        .i_mem_valid, .i_mem_data, .i_reg_addr, .i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata);
    fetch_memory_model i_mem (.i_clock, .i_rst, .i_req(o_mem_req), .i_addr(o_mem_addr), .i_slow(slow),
        .o_valid(i_mem_valid), .o_data(i_mem_data));
    task end_of_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    // Whole commands as one burst, valid held between dwords
    task send(input logic [31:0] d[$]);
        foreach (d[k]) begin
            i_cmd_dword <= d[k];
            i_cmd_valid <= 1'b1;
            do @(posedge i_clock); while (o_cmd_ready !== 1'b1);
        end
        i_cmd_valid <= 1'b0;
    endtask : send
    task fetch(input logic vtx, input logic [31:0] a, input logic [31:0] b, input logic [5:0] s);
        int n;
        got_moc = 4'h0;
        do @(posedge i_clock); while (o_fetch_ready !== 1'b1);
        i_idx_position <= a;
        i_vtx_vertex_index <= a;
        i_vtx_instance_index <= b;
        i_vtx_slot <= s;
        if (vtx) i_vtx_req <= 1'b1;
        else i_idx_req <= 1'b1;
        do @(posedge i_clock); while (o_fetch_ready !== 1'b1);
        i_idx_req <= 1'b0;
        i_vtx_req <= 1'b0;
        for (n = 0; n < 60; n++) begin
            @(posedge i_clock);
            if (o_mem_req === 1'b1) got_moc = o_mem_moc;
            if (o_idx_done === 1'b1 || o_vtx_done === 1'b1) break;
        end
        got = vtx ? o_vtx_data : o_idx_value;
        got_cut = o_idx_cut;
        if (n == 60) fails++;
    endtask : fetch
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_write <= 1'b1;
        @(posedge i_clock);
        i_reg_write <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_read <= 1'b1;
        @(posedge i_clock);
        i_reg_read <= 1'b0;
        @(posedge i_clock);
        got = o_reg_rdata;
    endtask : rd
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            end_of_test;
        end
    end
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        send('{32'h780A_5501, 32'h0000_1000, 32'h0000_10FF});
        fetch(0, 32'h0, 32'h0, 6'h00);
        `CHK("word index", 32'h0000_1000, got)
        `CHK("index moc", 4'h5, got_moc)
        fetch(0, 32'h1, 32'h0, 6'h00);
        `CHK("cut flag", 1'b1, got_cut)
        `CHK("cut value", 32'h0, got)
        fetch(0, 32'h80, 32'h0, 6'h00);
        `CHK("past end", 32'h0, got)
        i_idx_random <= 1'b0;
        fetch(0, 32'h1234, 32'h0, 6'h00);
        `CHK("sequential", 32'h0000_1234, got)
        i_idx_random <= 1'b1;
        rd(4'h4);
        `CHK("status", 32'h3, got & 32'h3F)
        rd(4'h8);
        `CHK("cut count", 32'h1, got)
        i_idx_topology <= TOPO_TRIFAN;
        fetch(0, 32'h0, 32'h0, 6'h00);
        rd(4'h4);
        `CHK("topology flag", 1'b1, got[3])
        i_idx_topology <= TOPO_TRILIST;
        send('{32'h780A_5001, 32'h0000_2000, 32'h0});
        fetch(0, 32'h3, 32'h0, 6'h00);
        `CHK("cut off value", 32'h0000_00FF, got)
        `CHK("cut off flag", 1'b0, got_cut)
        fetch(0, 32'h1, 32'h0, 6'h00);
        `CHK("byte lane", 32'h0000_0020, got)
        send('{32'h780A_5202, 32'h0000_3000, 32'h0, 32'hDEAD_BEEF});
        fetch(0, 32'h1, 32'h0, 6'h00);
        `CHK("fullword", 32'hFFFF_3004, got)
        slow <= 1'b1;
        send('{32'h7808_0007, 32'h0C09_0000, 32'h4000, 32'h40FF, 32'h0,
            32'h141A_0000, 32'h5000, 32'h50FF, 32'h0});
        fetch(1, 32'h2, 32'h7, 6'h03);
        `CHK("vertex data", 32'hFFFF_4024, got)
        `CHK("vertex moc", 4'h9, got_moc)
        fetch(1, 32'h2, 32'h7, 6'h05);
        `CHK("instance data", 32'hFFFF_5074, got)
        `CHK("instance moc", 4'hA, got_moc)
        fetch(1, 32'h10, 32'h7, 6'h03);
        `CHK("outside extent", 32'h0, got)
        i_vtx_generated_only <= 1'b1;
        fetch(1, 32'h2, 32'h7, 6'h03);
        `CHK("generated", 32'h0, got)
        `CHK("generated moc", 4'h0, got_moc)
        i_vtx_generated_only <= 1'b0;
        send('{32'h7808_0003, 32'h141A_0000, 32'h6000, 32'h60FF, 32'h0});
        fetch(1, 32'h2, 32'h7, 6'h03);
        `CHK("kept slot", 32'hFFFF_4024, got)
        fetch(1, 32'h2, 32'h7, 6'h05);
        `CHK("new slot", 32'hFFFF_6074, got)
        rd(4'h4);
        `CHK("no errors", 2'b00, got[5:4])
        send('{32'h7808_0103});
        rd(4'h4);
        `CHK("bad header", 1'b1, got[4])
        rd(4'hC);
        `CHK("unmapped", 32'h0, got)
        wr(4'h0, 32'h0);
        rd(4'h0);
        `CHK("ctrl", 32'h0, got)
        `CHK("fetch off", 1'b0, o_fetch_ready)
        end_of_test;
    end
endmodule : index_vertex_buffer_state_fetch_tb
`default_nettype wire
